// File: shared/dcci_pkg.sv
// constants and register map for the dual counter, command and interrupt block
package dcci_pkg;

    // ****************************************************************
    // register indices: byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] IDX_MODE0    = 8'h00;
    localparam logic [7:0] IDX_PRESET0  = 8'h02;
    localparam logic [7:0] IDX_CAPTURE0 = 8'h04;
    localparam logic [7:0] IDX_CMD0     = 8'h06;
    localparam logic [7:0] IDX_MODE1    = 8'h08;
    localparam logic [7:0] IDX_PRESET1  = 8'h0a;
    localparam logic [7:0] IDX_CAPTURE1 = 8'h0c;
    localparam logic [7:0] IDX_CMD1     = 8'h0e;
    localparam logic [7:0] IDX_SELECT   = 8'h20;
    localparam logic [7:0] IDX_IRQ      = 8'h22;
    localparam logic [7:0] IDX_IRQ_CLR  = 8'h24;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int GATE_POL_BIT  = 14;
    localparam int GATE_EDGE_BIT = 15;
    localparam int IRQ_W         = 5;
    localparam int IRQ_PORT_LSB  = 2;
    localparam int CMD_W         = 3;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [2:0] CMD_DISARM      = 3'h0;
    localparam logic [2:0] CMD_LOAD        = 3'h1;
    localparam logic [2:0] CMD_DISARM_SAVE = 3'h2;
    localparam logic [2:0] CMD_UNUSED      = 3'h3;
    localparam logic [2:0] CMD_ARM         = 3'h4;
    localparam logic [2:0] CMD_LOAD_ARM    = 3'h5;
    localparam logic [2:0] CMD_SAVE        = 3'h6;
    localparam logic [2:0] CMD_RESET       = 3'h7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [1:0]  SELECT_RST = 2'h0;
    localparam logic [4:0]  IRQ_RST    = 5'h00;

endpackage

// File: rtl/dcci_top.sv
// dual 16-bit counter with command, gating and interrupt logic behind an ahb-lite slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

// Overview of operation
// - polarity bit 0: gate active high in level mode, rising edge in edge mode
// - polarity bit 1: gate active low in level mode, falling edge in edge mode
// - gate activity bit picks level gating at 0, edge gating at 1
// - per-counter 16-bit writable preset register, counter 0 at 2h, counter 1 at Ah
// - per-counter 16-bit capture register, counter 0 at 4h, counter 1 at Ch
// - per-counter command register, 3-bit code in bits 2..0, at 6h and Eh
// - code 000 disarms, 100 arms, 111 resets the counter
// - code 001 loads preset into counter, armed state unchanged
// - code 010 disarms and saves count into capture register
// - code 101 loads preset then arms the counter
// - code 110 saves count into capture, armed state unchanged
// - select register at 20h, bits 1..0, one selects counter for commands
// - writing 22h bits 1..0 enables counter interrupts
// - bits 2, 3, 4 at 22h enable port a, b, c interrupts
// - reading 22h returns status, same layout as the enable bits
// - a status bit reads 1 once its source raised an interrupt, else 0
// - any write to 24h clears the interrupt status
module dcci_top #(
    parameter int NCNT = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [1:0]  gate_in,
    input  wire logic [1:0]  count_tick,
    input  wire logic        port_a_event,
    input  wire logic        port_b_event,
    input  wire logic        port_c_event,
    output logic      [1:0]  counter_armed,
    output logic      [1:0]  counter_tc,
    output logic             irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0][15:0]            mode;
        logic [1:0][15:0]            preset;
        logic [1:0][15:0]            capture;
        logic [1:0][15:0]            count;
        logic [1:0]                  armed;
        logic [1:0]                  gate_prev;
        logic [1:0]                  gate_seen;
        logic [1:0]                  tc;
        logic [1:0]                  select;
        logic [dcci_pkg::IRQ_W-1:0]  ien;
        logic [dcci_pkg::IRQ_W-1:0]  flags;
        logic                        irq;
        logic                        dp_wr;
        logic                        dp_rd;
        logic                        dp_ok;
        logic [7:0]                  dp_idx;
        logic                        hready;
        logic                        hresp;
        logic [31:0]                 hrdata;
    } dcci_state_t;

    dcci_state_t s_r;
    dcci_state_t s_nxt;

    logic [1:0]  cmd_fire;
    logic [1:0]  cmd_seen;
    logic [2:0]  cmd_code;
    logic        wr_ok;
    logic        clr_fire;

    localparam logic [1:0][7:0] IDX_CMD     = {dcci_pkg::IDX_CMD1, dcci_pkg::IDX_CMD0};
    localparam logic [1:0][7:0] IDX_PRESET  = {dcci_pkg::IDX_PRESET1, dcci_pkg::IDX_PRESET0};
    localparam logic [1:0][7:0] IDX_CAPTURE = {dcci_pkg::IDX_CAPTURE1, dcci_pkg::IDX_CAPTURE0};
    localparam logic [1:0][7:0] IDX_MODE    = {dcci_pkg::IDX_MODE1, dcci_pkg::IDX_MODE0};

    assign wr_ok    = s_r.dp_wr & s_r.dp_ok;
    assign cmd_code = hwdata[dcci_pkg::CMD_W-1:0];
    assign clr_fire = wr_ok & (s_r.dp_idx == dcci_pkg::IDX_IRQ_CLR);

    for (genvar g = 0; g < NCNT; g++) begin : g_cmd
        assign cmd_seen[g] = wr_ok & (s_r.dp_idx == IDX_CMD[g]);
        assign cmd_fire[g] = cmd_seen[g] & s_r.select[g];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic       acc;
        logic       pol;
        logic       edge_mode;
        logic       edge_now;
        logic       gate_ok;
        logic [4:0] ev;
        logic [15:0] wd;
        acc       = 1'b0;
        pol       = 1'b0;
        edge_mode = 1'b0;
        edge_now  = 1'b0;
        gate_ok   = 1'b0;
        ev        = '0;
        wd        = hwdata[15:0];
        s_nxt     = s_r;
        s_nxt.tc  = '0;

        // counters: a command in a cycle takes precedence over counting
        for (int i = 0; i < NCNT; i++) begin
            pol       = s_r.mode[i][dcci_pkg::GATE_POL_BIT];
            edge_mode = s_r.mode[i][dcci_pkg::GATE_EDGE_BIT];
            s_nxt.gate_prev[i] = gate_in[i];
            edge_now = pol ? (s_r.gate_prev[i] & ~gate_in[i])
                           : (~s_r.gate_prev[i] & gate_in[i]);
            if (edge_mode && edge_now && s_r.armed[i]) begin
                s_nxt.gate_seen[i] = 1'b1;
            end
            gate_ok = edge_mode ? s_r.gate_seen[i]
                                : (gate_in[i] ^ pol);
            if (cmd_fire[i]) begin
                unique case (cmd_code)
                    dcci_pkg::CMD_DISARM: begin
                        s_nxt.armed[i]     = 1'b0;
                        s_nxt.gate_seen[i] = 1'b0;
                    end
                    dcci_pkg::CMD_LOAD: begin
                        s_nxt.count[i] = s_r.preset[i];
                    end
                    dcci_pkg::CMD_DISARM_SAVE: begin
                        s_nxt.armed[i]     = 1'b0;
                        s_nxt.gate_seen[i] = 1'b0;
                        s_nxt.capture[i]   = s_r.count[i];
                    end
                    dcci_pkg::CMD_UNUSED: begin
                        s_nxt.armed[i] = s_r.armed[i];
                    end
                    dcci_pkg::CMD_ARM: begin
                        s_nxt.armed[i] = 1'b1;
                    end
                    dcci_pkg::CMD_LOAD_ARM: begin
                        s_nxt.count[i] = s_r.preset[i];
                        s_nxt.armed[i] = 1'b1;
                    end
                    dcci_pkg::CMD_SAVE: begin
                        s_nxt.capture[i] = s_r.count[i];
                    end
                    dcci_pkg::CMD_RESET: begin
                        s_nxt.count[i]     = dcci_pkg::CNT_RST;
                        s_nxt.armed[i]     = 1'b0;
                        s_nxt.gate_seen[i] = 1'b0;
                    end
                endcase
            end else if (s_r.armed[i] && gate_ok && count_tick[i]) begin
                // counts down; a tick at zero reloads the preset and flags terminal count
                if (s_r.count[i] == '0) begin
                    s_nxt.count[i] = s_r.preset[i];
                    s_nxt.tc[i]    = 1'b1;
                end else begin
                    s_nxt.count[i] = s_r.count[i] - 16'h0001;
                end
            end
            // plain register writes from software
            if (wr_ok && s_r.dp_idx == IDX_PRESET[i]) begin
                s_nxt.preset[i] = wd;
            end
            if (wr_ok && s_r.dp_idx == IDX_CAPTURE[i] && !(cmd_fire[i])) begin
                s_nxt.capture[i] = wd;
            end
            if (wr_ok && s_r.dp_idx == IDX_MODE[i]) begin
                s_nxt.mode[i] = '0;
                s_nxt.mode[i][dcci_pkg::GATE_POL_BIT]  = wd[dcci_pkg::GATE_POL_BIT];
                s_nxt.mode[i][dcci_pkg::GATE_EDGE_BIT] = wd[dcci_pkg::GATE_EDGE_BIT];
            end
        end

        if (wr_ok && s_r.dp_idx == dcci_pkg::IDX_SELECT) begin
            s_nxt.select = wd[1:0];
        end
        if (wr_ok && s_r.dp_idx == dcci_pkg::IDX_IRQ) begin
            s_nxt.ien = wd[dcci_pkg::IRQ_W-1:0];
        end

        // status is sticky; an event in the clearing cycle still sets its bit
        ev = {port_c_event, port_b_event, port_a_event, s_nxt.tc};
        s_nxt.flags = (clr_fire ? dcci_pkg::IRQ_RST : s_r.flags) | ev;
        s_nxt.irq   = |(s_nxt.flags & s_nxt.ien);

        // ahb-lite: writes zero wait; reads take one wait so they see the previous write
        acc          = hsel & htrans[1] & hready;
        s_nxt.dp_wr  = acc & hwrite;
        s_nxt.dp_rd  = acc & ~hwrite;
        s_nxt.hresp  = 1'b0;
        if (acc) begin
            s_nxt.dp_idx = haddr[9:2];
            s_nxt.dp_ok  = (haddr[31:10] == '0) && (haddr[1:0] == 2'h0);
            s_nxt.hready = hwrite;
        end
        if (s_r.dp_rd && !s_r.hready) begin
            s_nxt.hready = 1'b1;
            s_nxt.hrdata = 32'h0000_0000;
            if (s_r.dp_ok) begin
                unique case (s_r.dp_idx)
                    dcci_pkg::IDX_MODE0:    s_nxt.hrdata[15:0] = s_r.mode[0];
                    dcci_pkg::IDX_MODE1:    s_nxt.hrdata[15:0] = s_r.mode[1];
                    dcci_pkg::IDX_PRESET0:  s_nxt.hrdata[15:0] = s_r.preset[0];
                    dcci_pkg::IDX_PRESET1:  s_nxt.hrdata[15:0] = s_r.preset[1];
                    dcci_pkg::IDX_CAPTURE0: s_nxt.hrdata[15:0] = s_r.capture[0];
                    dcci_pkg::IDX_CAPTURE1: s_nxt.hrdata[15:0] = s_r.capture[1];
                    dcci_pkg::IDX_SELECT:   s_nxt.hrdata[1:0]  = s_r.select;
                    dcci_pkg::IDX_IRQ:      s_nxt.hrdata[dcci_pkg::IRQ_W-1:0] = s_r.flags;
                    default:                s_nxt.hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.hready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata        = s_r.hrdata;
    assign hreadyout     = s_r.hready;
    assign hresp         = s_r.hresp;
    assign counter_armed = s_r.armed;
    assign counter_tc    = s_r.tc;
    assign irq           = s_r.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_irq_output: assert property (
        irq == |(s_r.flags & s_r.ien))
        else $error("irq does not follow enabled status");

    chk_flag_clear: assert property (
        clr_fire && !port_a_event && !port_b_event && !port_c_event && !(|s_nxt.tc)
        |=> s_r.flags == '0)
        else $error("status not cleared by clear write");

    chk_port_flag: assert property (
        port_b_event |=> s_r.flags[dcci_pkg::IRQ_PORT_LSB + 1])
        else $error("port event did not set its status bit");

    chk_read_status: assert property (
        hsel && htrans[1] && hready && !hwrite && haddr == {22'h0, dcci_pkg::IDX_IRQ, 2'h0}
        && !clr_fire ##1 !port_a_event && !port_b_event && !port_c_event && !(|s_nxt.tc)
        |=> hreadyout && hrdata[dcci_pkg::IRQ_W-1:0] == $past(s_r.flags, 1))
        else $error("status read returned wrong value");

    chk_flag_sticky: assert property (
        !clr_fire |=> (s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
        else $error("status bit lost without a clear");

    chk_irq_holds: assert property (
        |(s_r.flags & s_r.ien) && !clr_fire && !(wr_ok && s_r.dp_idx == dcci_pkg::IDX_IRQ) |=> irq)
        else $error("enabled status did not hold irq");

    chk_enable_write: assert property (
        wr_ok && s_r.dp_idx == dcci_pkg::IDX_IRQ |=> s_r.ien == $past(hwdata[dcci_pkg::IRQ_W-1:0]))
        else $error("enable write not stored");

    chk_select_write: assert property (
        wr_ok && s_r.dp_idx == dcci_pkg::IDX_SELECT |=> s_r.select == $past(hwdata[1:0]))
        else $error("select write not stored");

    for (genvar g = 0; g < NCNT; g++) begin : g_chk
        chk_arm_cmd: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_ARM |=> s_r.armed[g])
            else $error("arm command did not arm");

        chk_disarm_cmd: assert property (
            cmd_fire[g] && (cmd_code == dcci_pkg::CMD_DISARM || cmd_code == dcci_pkg::CMD_DISARM_SAVE)
            |=> !s_r.armed[g])
            else $error("disarm command did not disarm");

        chk_load_cmd: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_LOAD
            |=> s_r.count[g] == $past(s_r.preset[g]) && s_r.armed[g] == $past(s_r.armed[g]))
            else $error("load command wrong");

        chk_save_cmd: assert property (
            cmd_fire[g] && (cmd_code == dcci_pkg::CMD_SAVE || cmd_code == dcci_pkg::CMD_DISARM_SAVE)
            |=> s_r.capture[g] == $past(s_r.count[g]))
            else $error("save command did not capture count");

        chk_reset_cmd: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_RESET |=> s_r.count[g] == '0 && !s_r.armed[g])
            else $error("reset command wrong");

        chk_unused_cmd: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_UNUSED
            |=> $stable(s_r.count[g]) && $stable(s_r.capture[g]) && $stable(s_r.armed[g]))
            else $error("unused code changed counter state");

        chk_select_gate: assert property (
            cmd_seen[g] && !s_r.select[g]
            |=> $stable(s_r.armed[g]) && $stable(s_r.capture[g]))
            else $error("command acted on unselected counter");

        chk_level_gate: assert property (
            !cmd_fire[g] && !s_r.mode[g][dcci_pkg::GATE_EDGE_BIT]
            && (gate_in[g] == s_r.mode[g][dcci_pkg::GATE_POL_BIT])
            |=> $stable(s_r.count[g]))
            else $error("counter moved with inactive level gate");

        chk_load_arm_cmd: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_LOAD_ARM
            |=> s_r.count[g] == $past(s_r.preset[g]) && s_r.armed[g])
            else $error("load and arm command wrong");

        chk_save_keeps_arm: assert property (
            cmd_fire[g] && cmd_code == dcci_pkg::CMD_SAVE |=> s_r.armed[g] == $past(s_r.armed[g]))
            else $error("save command changed armed state");

        chk_preset_write: assert property (
            wr_ok && s_r.dp_idx == IDX_PRESET[g] |=> s_r.preset[g] == $past(hwdata[15:0]))
            else $error("preset write not stored");

        chk_capture_write: assert property (
            wr_ok && s_r.dp_idx == IDX_CAPTURE[g] |=> s_r.capture[g] == $past(hwdata[15:0]))
            else $error("capture write not stored");

        chk_level_count: assert property (
            !cmd_fire[g] && s_r.armed[g] && !s_r.mode[g][dcci_pkg::GATE_EDGE_BIT] && count_tick[g]
            && (gate_in[g] != s_r.mode[g][dcci_pkg::GATE_POL_BIT]) && s_r.count[g] != 16'h0000
            |=> s_r.count[g] == $past(s_r.count[g]) - 16'h0001)
            else $error("counter did not step with active level gate");

        chk_tc_reload: assert property (
            !cmd_fire[g] && s_r.armed[g] && !s_r.mode[g][dcci_pkg::GATE_EDGE_BIT] && count_tick[g]
            && (gate_in[g] != s_r.mode[g][dcci_pkg::GATE_POL_BIT]) && s_r.count[g] == 16'h0000
            |=> s_r.tc[g] && s_r.flags[g] && s_r.count[g] == $past(s_r.preset[g]))
            else $error("terminal count did not reload and flag");

        chk_edge_hold: assert property (
            !cmd_fire[g] && s_r.mode[g][dcci_pkg::GATE_EDGE_BIT] && !s_r.gate_seen[g]
            |=> $stable(s_r.count[g]))
            else $error("counter moved before an active gate edge");

        chk_rise_edge: assert property (
            !cmd_fire[g] && s_r.armed[g] && s_r.mode[g][dcci_pkg::GATE_EDGE_BIT]
            && !s_r.mode[g][dcci_pkg::GATE_POL_BIT] && !$past(gate_in[g]) && gate_in[g] |=> s_r.gate_seen[g])
            else $error("rising gate edge not taken");

        chk_fall_edge: assert property (
            !cmd_fire[g] && s_r.armed[g] && s_r.mode[g][dcci_pkg::GATE_EDGE_BIT]
            && s_r.mode[g][dcci_pkg::GATE_POL_BIT] && $past(gate_in[g]) && !gate_in[g] |=> s_r.gate_seen[g])
            else $error("falling gate edge not taken");
    end

endmodule

// File: tb/dcci_host.sv
// host processor model issuing single-word ahb-lite transfers
`timescale 1ns/1ps
module dcci_host (
    input  wire logic        sys_clk,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ****************************************************************
    // one transfer; waits on hready as long as the slave needs
    // ****************************************************************
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~haddr;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        // released data lines must not keep showing the old word
        hwdata <= ~wd;
    endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench comparing the counter block with a behavioural model
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  gate_in    = 2'h3;
    logic [1:0]  count_tick = 2'h0;
    logic [2:0]  pev        = 3'h0;
    logic [1:0]  counter_armed;
    logic [1:0]  counter_tc;
    logic        irq;
    logic [31:0] rdv;
    int          error_cnt  = 0;
    int          checked    = 0;
    int          seed       = 32'hb8bd25d8;
    int          cnt[2], pre[2], cap[2], arm[2], pol[2], edg[2], es[2];
    int          gl[2]      = '{1, 1};
    int          sel        = 0;
    int          st         = 0;
    int          tcn        = 0;
    int          tce        = 0;

    always #4 sys_clk = ~sys_clk;

    // terminal count pulses seen on the pins, held against the model's count
    always @(posedge sys_clk) begin
        if (counter_tc[0] === 1'b1) tcn++;
        if (counter_tc[1] === 1'b1) tcn++;
    end

    dcci_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gate_in(gate_in), .count_tick(count_tick),
        .port_a_event(pev[0]), .port_b_event(pev[1]), .port_c_event(pev[2]),
        .counter_armed(counter_armed), .counter_tc(counter_tc), .irq(irq));

    dcci_host host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // ****************************************************************
    // compare, bus and model tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, idx, d, rdv);
    endtask

    task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, idx, $random(seed), rdv);
        chk(nm, exp, rdv);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // model acts only for selected counters; the design ignores the rest
    task automatic cmd(input int i, input logic [2:0] c);
        wr(i ? dcci_pkg::IDX_CMD1 : dcci_pkg::IDX_CMD0, {29'h0, c});
        if (sel[i]) begin
            if (c == dcci_pkg::CMD_LOAD || c == dcci_pkg::CMD_LOAD_ARM) cnt[i] = pre[i];
            if (c == dcci_pkg::CMD_DISARM_SAVE || c == dcci_pkg::CMD_SAVE) cap[i] = cnt[i];
            if (c == dcci_pkg::CMD_RESET) cnt[i] = 0;
            if (c == dcci_pkg::CMD_ARM || c == dcci_pkg::CMD_LOAD_ARM) arm[i] = 1;
            if (c == dcci_pkg::CMD_DISARM || c == dcci_pkg::CMD_DISARM_SAVE || c == dcci_pkg::CMD_RESET) begin
                arm[i] = 0;
                es[i] = 0;
            end
        end
        @(posedge sys_clk);
        chk("armed", arm[i], counter_armed[i]);
    endtask

    task automatic sv(input int i);
        cmd(i, dcci_pkg::CMD_SAVE);
        rd("capture", i ? dcci_pkg::IDX_CAPTURE1 : dcci_pkg::IDX_CAPTURE0, cap[i]);
    endtask

    task automatic tick(input int i, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            count_tick[i] <= 1'b1;
            if (arm[i] != 0 && (edg[i] != 0 ? es[i] != 0 : gl[i] != pol[i])) begin
                // zero reloads the preset and pulses terminal count
                if (cnt[i] == 0) begin
                    cnt[i] = pre[i];
                    tce++;
                end else begin
                    cnt[i]--;
                end
            end
        end
        @(posedge sys_clk);
        count_tick[i] <= 1'b0;
    endtask

    task automatic gate(input int i, input int lvl);
        @(posedge sys_clk);
        gate_in[i] <= lvl[0];
        if (arm[i] != 0 && edg[i] != 0 && lvl != gl[i] && lvl != pol[i]) es[i] = 1;
        gl[i] = lvl;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic mode(input int i, input int p, input int e);
        wr(i ? dcci_pkg::IDX_MODE1 : dcci_pkg::IDX_MODE0, (32'(e) << 15) | (32'(p) << 14));
        pol[i] = p;
        edg[i] = e;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd("select", dcci_pkg::IDX_SELECT, 32'h0);
        rd("status", dcci_pkg::IDX_IRQ, 32'h0);
        rd("preset", dcci_pkg::IDX_PRESET1, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h30, $random(seed));
        rd("unmapped", 8'h30, 32'h0);
        rd("command", dcci_pkg::IDX_CMD0, 32'h0);
        cap[1] = $random(seed) & 32'hffff;
        wr(dcci_pkg::IDX_CAPTURE1, cap[1]);
        rd("capture", dcci_pkg::IDX_CAPTURE1, cap[1]);
        cmd(0, dcci_pkg::CMD_LOAD_ARM);
        sel = 3;
        wr(dcci_pkg::IDX_SELECT, 32'h3);
        rd("select", dcci_pkg::IDX_SELECT, 32'h3);
        for (int i = 0; i < 2; i++) begin
            pre[i] = ($random(seed) & 32'hfeff) | 32'h0100;
            wr(i ? dcci_pkg::IDX_PRESET1 : dcci_pkg::IDX_PRESET0, pre[i]);
            rd("preset", i ? dcci_pkg::IDX_PRESET1 : dcci_pkg::IDX_PRESET0, pre[i]);
            cmd(i, dcci_pkg::CMD_LOAD);
            sv(i);
            cmd(i, dcci_pkg::CMD_ARM);
            tick(i, 5);
            cmd(i, dcci_pkg::CMD_UNUSED);
            cmd(i, dcci_pkg::CMD_DISARM_SAVE);
            rd("capture", i ? dcci_pkg::IDX_CAPTURE1 : dcci_pkg::IDX_CAPTURE0, cap[i]);
            tick(i, 3);
            sv(i);
            cmd(i, dcci_pkg::CMD_LOAD_ARM);
            tick(i, 2);
            cmd(i, dcci_pkg::CMD_DISARM);
            sv(i);
            cmd(i, dcci_pkg::CMD_RESET);
            sv(i);
        end
        mode(0, 1, 0);
        cmd(0, dcci_pkg::CMD_LOAD_ARM);
        tick(0, 4);
        gate(0, 0);
        tick(0, 3);
        sv(0);
        mode(0, 0, 1);
        cmd(0, dcci_pkg::CMD_DISARM);
        cmd(0, dcci_pkg::CMD_LOAD_ARM);
        tick(0, 2);
        gate(0, 1);
        tick(0, 2);
        sv(0);
        mode(0, 1, 1);
        cmd(0, dcci_pkg::CMD_DISARM);
        cmd(0, dcci_pkg::CMD_LOAD_ARM);
        gate(0, 0);
        tick(0, 3);
        sv(0);
        sel = 1;
        wr(dcci_pkg::IDX_SELECT, 32'h1);
        cmd(1, dcci_pkg::CMD_ARM);
        sel = 3;
        wr(dcci_pkg::IDX_SELECT, 32'h3);
        wr(dcci_pkg::IDX_IRQ, 32'h0);
        pre[1] = 1;
        wr(dcci_pkg::IDX_PRESET1, 32'h1);
        cmd(1, dcci_pkg::CMD_LOAD_ARM);
        tick(1, 2);
        st = 2;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            pev[k] <= 1'b1;
            @(posedge sys_clk);
            pev[k] <= 1'b0;
            st = st | (4 << k);
        end
        chk("tc pulses", tce, tcn);
        rd("status", dcci_pkg::IDX_IRQ, st);
        chk("irq", 32'h0, {31'h0, irq});
        wr(dcci_pkg::IDX_IRQ, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        for (int b = 1; b < 5; b++) begin
            wr(dcci_pkg::IDX_IRQ, 32'h1 << b);
            repeat (2) @(posedge sys_clk);
            chk("irq", 32'h1, {31'h0, irq});
        end
        wr(dcci_pkg::IDX_IRQ_CLR, $random(seed));
        rd("status", dcci_pkg::IDX_IRQ, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        conclude();
    end
endmodule
